// ### cdg_pkg.sv
// Purpose: shared constants and types for the complementary dead-band generator
// Assumes: one 10 MHz clock, 8-bit register port
// Notes: offsets are byte addresses on the plain register port
package cdg_pkg;

    // register port shape
    localparam int CDG_ADDR_W = 3;
    localparam int CDG_DATA_W = 8;
    localparam int CDG_DB_W = 6;
    localparam int CDG_NUM_SRC = 4;

    // register offsets
    localparam logic [2:0] CDG_REG_CTRL0 = 3'h0;
    localparam logic [2:0] CDG_REG_CTRL1 = 3'h1;
    localparam logic [2:0] CDG_REG_RISE_DB = 3'h2;
    localparam logic [2:0] CDG_REG_FALL_DB = 3'h3;
    localparam logic [2:0] CDG_REG_STATUS = 3'h4;

    // generator_control_zero fields
    localparam int CDG_C0_EN_BIT = 7;
    localparam int CDG_C0_OEB_BIT = 6;
    localparam int CDG_C0_OEA_BIT = 5;
    localparam int CDG_C0_POLB_BIT = 4;
    localparam int CDG_C0_POLA_BIT = 3;
    localparam int CDG_C0_CS_BIT = 0;
    localparam logic [7:0] CDG_CTRL0_MASK = 8'hF9;

    // generator_control_one fields
    localparam int CDG_C1_OVR_BIT = 7;
    localparam int CDG_C1_LVLB_BIT = 6;
    localparam int CDG_C1_LVLA_BIT = 5;
    localparam int CDG_C1_SEL_LSB = 0;
    localparam logic [7:0] CDG_CTRL1_MASK = 8'hE7;

    // status fields
    localparam int CDG_ST_PACT_BIT = 0;
    localparam int CDG_ST_CACT_BIT = 1;
    localparam int CDG_ST_SRC_BIT = 2;
    localparam int CDG_ST_PPIN_BIT = 3;
    localparam int CDG_ST_CPIN_BIT = 4;

    // reset values
    localparam logic [7:0] CDG_CTRL0_RST = 8'h00;
    localparam logic [7:0] CDG_CTRL1_RST = 8'h00;
    localparam logic [5:0] CDG_DB_RST = 6'h00;

    // input_source_select codes
    localparam logic [2:0] CDG_SRC_CMP = 3'h0;
    localparam logic [2:0] CDG_SRC_PG1 = 3'h1;
    localparam logic [2:0] CDG_SRC_PG2 = 3'h2;
    localparam logic [2:0] CDG_SRC_PG3 = 3'h3;

    // counting clock rates, the fast one modelled by a rate accumulator
    localparam int CDG_SYS_CLK_KHZ = 10000;
    localparam int CDG_FAST_OSC_KHZ = 16000;
    localparam int CDG_ACC_W = 15;
    localparam logic [14:0] CDG_ACC_SYS = 15'(CDG_SYS_CLK_KHZ);
    localparam logic [14:0] CDG_ACC_FAST = 15'(CDG_FAST_OSC_KHZ);
    localparam logic [14:0] CDG_ACC_TWO = 15'(2 * CDG_SYS_CLK_KHZ);
    localparam logic [1:0] CDG_STEP_ONE = 2'h1;
    localparam logic [1:0] CDG_STEP_TWO = 2'h2;

    typedef enum logic [1:0] {
        CDG_TMR_IDLE = 2'b00,
        CDG_TMR_COUNT = 2'b01
    } cdg_tmr_state_t;

endpackage

// ### cdg_edge_timer.sv
// Purpose: one dead-band timer, started by an input edge, ends in a drive level
// Assumes: start is a one-cycle pulse on ref_clk; cancel may stay high for many cycles
// Notes: cancel wins over start and over completion
`timescale 1ns/100ps
module cdg_edge_timer import cdg_pkg::*; #(
    parameter int CNT_W = CDG_DB_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // control
    input wire logic start,
    input wire logic cancel,
    input wire logic [CNT_W-1:0] limit,
    input wire logic [1:0] step,
    // result
    output logic active
);

    typedef struct packed {
        cdg_tmr_state_t state;
        logic [CNT_W:0] count;
        logic on;
    } cdg_tmr_st_t;

    cdg_tmr_st_t st_r;
    cdg_tmr_st_t st_nxt;
    logic [CNT_W:0] sum;

    assign sum = st_r.count + (CNT_W+1)'(step);

    always_comb begin
        st_nxt = st_r;
        case (st_r.state)
            CDG_TMR_IDLE: begin
                st_nxt.state = CDG_TMR_IDLE;
            end
            CDG_TMR_COUNT: begin
                // count periods up from zero until the programmed value
                if (sum >= {1'b0, limit}) begin
                    st_nxt.on = 1'b1;
                    st_nxt.state = CDG_TMR_IDLE;
                end else begin
                    st_nxt.count = sum;
                end
            end
            default: begin
                st_nxt.state = CDG_TMR_IDLE;
            end
        endcase
        if (start) begin
            st_nxt.count = '0;
            if (limit == '0) begin
                st_nxt.on = 1'b1;
                st_nxt.state = CDG_TMR_IDLE;
            end else begin
                st_nxt.on = 1'b0;
                st_nxt.state = CDG_TMR_COUNT;
            end
        end
        // opposite edge aborts a pending turn-on
        if (cancel) begin
            st_nxt.on = 1'b0;
            st_nxt.count = '0;
            st_nxt.state = CDG_TMR_IDLE;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '{state: CDG_TMR_IDLE, count: '0, on: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign active = st_r.on;

    a_zero_limit: assert property (@(posedge ref_clk) disable iff (!nrst)
        start && !cancel && limit == '0 |=> active)
        else $error("zero dead band did not turn on at once");

    a_cancel_clears: assert property (@(posedge ref_clk) disable iff (!nrst)
        cancel |=> !active)
        else $error("cancel left the drive on");

endmodule

// ### cdg_core.sv
// Purpose: complementary drive pair with rising and falling dead band
// Assumes: pulse and comparator inputs are asynchronous pins
// Notes: fast counting clock is modelled as 1.6 counts per system cycle
//
// Notes on behaviour
// - two drives, primary and complement, come from the one selected source
// - dead-band counts run on system clock or the 16 MHz fast oscillator
// - clock select one picks fast oscillator, zero picks system clock
// - three-bit field picks comparator or one of three pulse generators
// - enabling the module starts with both drives cleared
// - a cleared output enable leaves the pin undriven
// - an enabled output shows the override level or the active waveform
// - with the module disabled, enables and drive levels have no effect
// - per-output polarity: set means active high, cleared active low
// - polarity applies to the waveform only, never the override level
// - separate 6-bit counters for rising and falling edges
// - dead time counts clock periods up from zero to the programmed value
// - rising edge drops complement at once, primary on after rise count
// - falling edge drops primary at once, complement on after fall count
// - each dead band is programmable over the full counter range
// - a zero value inserts no dead time
// - input shorter than the count never turns the drive on
// - dead time varies by at most one counting period
`timescale 1ns/100ps
module cdg_core import cdg_pkg::*; #(
    parameter int ADDR_W = CDG_ADDR_W,
    parameter int DATA_W = CDG_DATA_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // waveform sources
    input wire logic comparator_synced_output,
    input wire logic first_pulse_gen_output,
    input wire logic second_pulse_gen_output,
    input wire logic third_pulse_gen_output,
    // drive pins
    output logic primary_drive_out,
    output logic primary_drive_oe,
    output logic complement_drive_out,
    output logic complement_drive_oe
);

    typedef struct packed {
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [CDG_DB_W-1:0] rise_db;
        logic [CDG_DB_W-1:0] fall_db;
        logic [CDG_NUM_SRC-1:0] sync1;
        logic [CDG_NUM_SRC-1:0] sync2;
        logic src_prev;
        logic [CDG_ACC_W-1:0] acc;
        logic prim_pin;
        logic prim_oe;
        logic comp_pin;
        logic comp_oe;
        logic [DATA_W-1:0] rd_data;
    } cdg_core_st_t;

    cdg_core_st_t st_r;
    cdg_core_st_t st_nxt;

    logic [CDG_NUM_SRC-1:0] src_pins;
    logic src_now;
    logic rise_edge;
    logic fall_edge;
    logic module_enable_bit;
    logic primary_out_enable;
    logic complement_out_enable;
    logic primary_polarity;
    logic complement_polarity;
    logic counting_clock_select;
    logic override_on;
    logic [2:0] input_source_select;
    logic prim_act;
    logic comp_act;
    logic [1:0] step;
    logic [CDG_ACC_W-1:0] acc_sum;

    // picks one synchronised source; unused codes give a quiet low
    function automatic logic pick_source(input logic [CDG_NUM_SRC-1:0] s,
                                         input logic [2:0] sel);
        logic v;
        v = 1'b0;
        if (sel == CDG_SRC_CMP) begin
            v = s[0];
        end else if (sel == CDG_SRC_PG1) begin
            v = s[1];
        end else if (sel == CDG_SRC_PG2) begin
            v = s[2];
        end else if (sel == CDG_SRC_PG3) begin
            v = s[3];
        end
        return v;
    endfunction

    // drive level before the pin, override bypasses polarity
    function automatic logic pin_level(input logic ovr, input logic lvl,
                                       input logic pol, input logic act);
        logic v;
        v = ovr ? lvl : (pol ? act : ~act);
        return v;
    endfunction

    assign src_pins = {third_pulse_gen_output, second_pulse_gen_output,
                       first_pulse_gen_output, comparator_synced_output};

    assign module_enable_bit = st_r.ctrl0[CDG_C0_EN_BIT];
    assign primary_out_enable = st_r.ctrl0[CDG_C0_OEA_BIT];
    assign complement_out_enable = st_r.ctrl0[CDG_C0_OEB_BIT];
    assign primary_polarity = st_r.ctrl0[CDG_C0_POLA_BIT];
    assign complement_polarity = st_r.ctrl0[CDG_C0_POLB_BIT];
    assign counting_clock_select = st_r.ctrl0[CDG_C0_CS_BIT];
    assign override_on = st_r.ctrl1[CDG_C1_OVR_BIT];
    assign input_source_select = st_r.ctrl1[CDG_C1_SEL_LSB +: 3];

    // source is read only after two flops, so edges land on a clock
    assign src_now = pick_source(st_r.sync2, input_source_select);
    assign rise_edge = src_now & ~st_r.src_prev;
    assign fall_edge = ~src_now & st_r.src_prev;

    // counts per system cycle: 1, or 1.6 on average for the fast oscillator
    assign acc_sum = st_r.acc + CDG_ACC_FAST;
    always_comb begin
        step = CDG_STEP_ONE;
        if (counting_clock_select && acc_sum >= CDG_ACC_TWO) begin
            step = CDG_STEP_TWO;
        end
    end

    // rising edge timer: starts primary turn-on, drops complement
    cdg_edge_timer #(
        .CNT_W(CDG_DB_W)
    ) u_rise_timer (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .start(rise_edge & module_enable_bit),
        .cancel(fall_edge | ~module_enable_bit),
        .limit(st_r.rise_db),
        .step(step),
        .active(prim_act)
    );

    // falling edge timer: starts complement turn-on, drops primary
    cdg_edge_timer #(
        .CNT_W(CDG_DB_W)
    ) u_fall_timer (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .start(fall_edge & module_enable_bit),
        .cancel(rise_edge | ~module_enable_bit),
        .limit(st_r.fall_db),
        .step(step),
        .active(comp_act)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.sync1 = src_pins;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.src_prev = src_now;

        // rate accumulator only runs for the fast counting clock
        if (counting_clock_select) begin
            if (acc_sum >= CDG_ACC_TWO) begin
                st_nxt.acc = acc_sum - CDG_ACC_TWO;
            end else begin
                st_nxt.acc = acc_sum - CDG_ACC_SYS;
            end
        end else begin
            st_nxt.acc = '0;
        end

        // register writes
        if (reg_wr) begin
            if (reg_addr == CDG_REG_CTRL0) begin
                st_nxt.ctrl0 = reg_wdata & CDG_CTRL0_MASK;
            end else if (reg_addr == CDG_REG_CTRL1) begin
                st_nxt.ctrl1 = reg_wdata & CDG_CTRL1_MASK;
            end else if (reg_addr == CDG_REG_RISE_DB) begin
                st_nxt.rise_db = reg_wdata[CDG_DB_W-1:0];
            end else if (reg_addr == CDG_REG_FALL_DB) begin
                st_nxt.fall_db = reg_wdata[CDG_DB_W-1:0];
            end
        end

        // pins: enable gated by module enable, level by override or polarity
        st_nxt.prim_oe = module_enable_bit & primary_out_enable;
        st_nxt.comp_oe = module_enable_bit & complement_out_enable;
        st_nxt.prim_pin = st_nxt.prim_oe &
            pin_level(override_on, st_r.ctrl1[CDG_C1_LVLA_BIT],
                      primary_polarity, prim_act);
        st_nxt.comp_pin = st_nxt.comp_oe &
            pin_level(override_on, st_r.ctrl1[CDG_C1_LVLB_BIT],
                      complement_polarity, comp_act);

        // read data stands for one cycle only
        st_nxt.rd_data = '0;
        if (reg_rd) begin
            if (reg_addr == CDG_REG_CTRL0) begin
                st_nxt.rd_data = st_r.ctrl0;
            end else if (reg_addr == CDG_REG_CTRL1) begin
                st_nxt.rd_data = st_r.ctrl1;
            end else if (reg_addr == CDG_REG_RISE_DB) begin
                st_nxt.rd_data = DATA_W'(st_r.rise_db);
            end else if (reg_addr == CDG_REG_FALL_DB) begin
                st_nxt.rd_data = DATA_W'(st_r.fall_db);
            end else if (reg_addr == CDG_REG_STATUS) begin
                st_nxt.rd_data[CDG_ST_PACT_BIT] = prim_act;
                st_nxt.rd_data[CDG_ST_CACT_BIT] = comp_act;
                st_nxt.rd_data[CDG_ST_SRC_BIT] = src_now;
                st_nxt.rd_data[CDG_ST_PPIN_BIT] = st_r.prim_pin;
                st_nxt.rd_data[CDG_ST_CPIN_BIT] = st_r.comp_pin;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '{ctrl0: CDG_CTRL0_RST, ctrl1: CDG_CTRL1_RST,
                      rise_db: CDG_DB_RST, fall_db: CDG_DB_RST,
                      sync1: '0, sync2: '0, src_prev: 1'b0, acc: '0,
                      prim_pin: 1'b0, prim_oe: 1'b0, comp_pin: 1'b0,
                      comp_oe: 1'b0, rd_data: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rd_data;
    assign primary_drive_out = st_r.prim_pin;
    assign primary_drive_oe = st_r.prim_oe;
    assign complement_drive_out = st_r.comp_pin;
    assign complement_drive_oe = st_r.comp_oe;

    a_no_overlap: assert property (@(posedge ref_clk) disable iff (!nrst)
        !(prim_act && comp_act))
        else $error("both drives active together");

    a_rise_drops_comp: assert property (@(posedge ref_clk) disable iff (!nrst)
        rise_edge |=> !comp_act)
        else $error("complement not dropped on rising edge");

    a_fall_drops_prim: assert property (@(posedge ref_clk) disable iff (!nrst)
        fall_edge |=> !prim_act)
        else $error("primary not dropped on falling edge");

    a_rise_db_three: assert property (@(posedge ref_clk) disable iff (!nrst)
        rise_edge && module_enable_bit && !counting_clock_select && st_r.rise_db == 6'h03
        ##1 (!fall_edge && module_enable_bit && !counting_clock_select
             && st_r.rise_db == 6'h03)[*3]
        |-> !prim_act ##1 prim_act)
        else $error("rising dead band of three not honoured");

    a_fall_db_two: assert property (@(posedge ref_clk) disable iff (!nrst)
        fall_edge && module_enable_bit && !counting_clock_select && st_r.fall_db == 6'h02
        ##1 (!rise_edge && module_enable_bit && !counting_clock_select
             && st_r.fall_db == 6'h02)[*2]
        |-> !comp_act ##1 comp_act)
        else $error("falling dead band of two not honoured");

    a_short_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
        rise_edge && !counting_clock_select && st_r.rise_db != 6'h00 ##1 fall_edge
        |-> (!prim_act)[*3])
        else $error("short input pulse turned primary on");

    a_enable_clears: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(module_enable_bit) |-> !prim_act && !comp_act)
        else $error("drives not cleared when module enabled");

    a_disabled_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
        !module_enable_bit |=> !primary_drive_oe && !complement_drive_oe
                               && !primary_drive_out && !complement_drive_out)
        else $error("disabled module still drives a pin");

    a_oe_follows: assert property (@(posedge ref_clk) disable iff (!nrst)
        module_enable_bit && !complement_out_enable |=> !complement_drive_oe)
        else $error("complement driven with its enable cleared");

    a_polarity_pin: assert property (@(posedge ref_clk) disable iff (!nrst)
        module_enable_bit && primary_out_enable && !override_on
        |=> primary_drive_out == ($past(primary_polarity) ? $past(prim_act)
                                                          : !$past(prim_act)))
        else $error("primary pin ignores polarity");

    a_override_level: assert property (@(posedge ref_clk) disable iff (!nrst)
        module_enable_bit && complement_out_enable && override_on
        |=> complement_drive_out == $past(st_r.ctrl1[CDG_C1_LVLB_BIT]))
        else $error("override level altered");

    a_fast_rate: assert property (@(posedge ref_clk) disable iff (!nrst)
        counting_clock_select && $past(counting_clock_select, 1)
        && $past(counting_clock_select, 2) && $past(counting_clock_select, 3)
        && $past(counting_clock_select, 4)
        |-> 4'(step) + 4'($past(step, 1)) + 4'($past(step, 2)) + 4'($past(step, 3))
            + 4'($past(step, 4)) == 4'h8)
        else $error("fast counting rate is not 16 per 10 cycles");

    a_sys_rate: assert property (@(posedge ref_clk) disable iff (!nrst)
        !counting_clock_select |-> step == CDG_STEP_ONE)
        else $error("system clock mode counts faster than one");

    a_rise_zero_on: assert property (@(posedge ref_clk) disable iff (!nrst)
        rise_edge && module_enable_bit && st_r.rise_db == 6'h00 |=> prim_act)
        else $error("zero rising dead band delayed primary");

    a_fall_zero_on: assert property (@(posedge ref_clk) disable iff (!nrst)
        fall_edge && module_enable_bit && st_r.fall_db == 6'h00 |=> comp_act)
        else $error("zero falling dead band delayed complement");

    a_rise_waits: assert property (@(posedge ref_clk) disable iff (!nrst)
        rise_edge && module_enable_bit && st_r.rise_db != 6'h00 |=> !prim_act)
        else $error("primary on before rising dead band");

    a_prim_holds: assert property (@(posedge ref_clk) disable iff (!nrst)
        prim_act && !fall_edge && module_enable_bit |=> prim_act)
        else $error("primary dropped without falling edge");

    a_comp_holds: assert property (@(posedge ref_clk) disable iff (!nrst)
        comp_act && !rise_edge && module_enable_bit |=> comp_act)
        else $error("complement dropped without rising edge");

    a_prim_oe_off: assert property (@(posedge ref_clk) disable iff (!nrst)
        !primary_out_enable |=> !primary_drive_oe)
        else $error("primary driven with its enable cleared");

    a_comp_polarity: assert property (@(posedge ref_clk) disable iff (!nrst)
        module_enable_bit && complement_out_enable && !override_on
        |=> complement_drive_out == ($past(complement_polarity) ? $past(comp_act)
                                                                : !$past(comp_act)))
        else $error("complement pin ignores polarity");

    a_prim_override: assert property (@(posedge ref_clk) disable iff (!nrst)
        module_enable_bit && primary_out_enable && override_on
        |=> primary_drive_out == $past(st_r.ctrl1[CDG_C1_LVLA_BIT]))
        else $error("primary override level altered");

    a_unused_src: assert property (@(posedge ref_clk) disable iff (!nrst)
        input_source_select > CDG_SRC_PG3 |-> !src_now)
        else $error("unused source code not quiet");

    a_sync_delay: assert property (@(posedge ref_clk) disable iff (!nrst)
        input_source_select == CDG_SRC_CMP
        |-> src_now == $past(comparator_synced_output, 2))
        else $error("comparator not seen after two flops");

endmodule

// ### cdg_gate_load.sv
// Purpose: gate driver load seen on the two drive pins
// Assumes: the gate driver pulls a released pin low
// Notes: flags both switches on together
`timescale 1ns/100ps
module cdg_gate_load (
    // drive pins from the generator
    input wire logic primary_drive_out,
    input wire logic primary_drive_oe,
    input wire logic complement_drive_out,
    input wire logic complement_drive_oe,
    // levels seen by the switches
    output logic pin_a,
    output logic pin_b,
    output logic both_on
);
    // released pin falls to the pull-down level
    assign pin_a = primary_drive_oe ? primary_drive_out : 1'b0;
    assign pin_b = complement_drive_oe ? complement_drive_out : 1'b0;
    assign both_on = pin_a & pin_b;
endmodule

// ### complementary_deadband_gen_tb_top.sv
// Purpose: self-checking bench for the complementary dead-band generator
// Assumes: unselected sources carry random noise during waveform tests
// Notes: pin changes are matched against notes queued by the driver
`timescale 1ns/100ps
module complementary_deadband_gen_tb_top import cdg_pkg::*;;
    typedef struct {
        logic pin;
        logic lvl;
        int ref_c;
        int lo;
        int hi;
    } cdg_note_t;
    logic ref_clk, nrst, reg_wr, reg_rd, watch, rd_seen, prev_a, prev_b;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [3:0] srcs;
    logic pa_out, pa_oe, pb_out, pb_oe, pin_a, pin_b, both_on;
    logic pol_a, pol_b, fast, a_on, b_on;
    logic [1:0] sel;
    logic [5:0] nr, nf;
    logic [7:0] exp_rb[6];
    logic [5:0] nr_tab[4];
    logic [5:0] nf_tab[4];
    int cyc, last_ev, num_errors, check_count;
    logic [7:0] rd_q[$];
    cdg_note_t ev_q[$];

    cdg_core i_dut (
        .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .comparator_synced_output(srcs[0]), .first_pulse_gen_output(srcs[1]),
        .second_pulse_gen_output(srcs[2]), .third_pulse_gen_output(srcs[3]),
        .primary_drive_out(pa_out), .primary_drive_oe(pa_oe),
        .complement_drive_out(pb_out), .complement_drive_oe(pb_oe)
    );
    cdg_gate_load i_load (
        .primary_drive_out(pa_out), .primary_drive_oe(pa_oe),
        .complement_drive_out(pb_out), .complement_drive_oe(pb_oe),
        .pin_a(pin_a), .pin_b(pin_b), .both_on(both_on)
    );

    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    task automatic err(input string m);
        num_errors++;
        $display("ERROR at %0t: %s", $time, m);
    endtask

    task automatic results();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) err($sformatf("read data %h, expected %h", got, exp));
    endtask

    task automatic cmp_ev(input cdg_note_t n, input logic v);
        int d;
        d = cyc - ((n.ref_c < 0) ? last_ev : n.ref_c);
        last_ev = cyc;
        check_count++;
        if (v !== n.lvl || d < n.lo || d > n.hi)
            err($sformatf("pin %0d went %b after %0d cycles", n.pin, v, d));
    endtask

    task automatic chk_pins(input logic [3:0] exp);
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        check_count++;
        if ({pa_oe, pa_out, pb_oe, pb_out} !== exp) err("drive pin state mismatch");
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic done(input string name);
        $display("test %s done at %0t", name, $time);
    endtask

    // one source edge, then hold it with noise on the other sources
    task automatic src_edge(input logic lvl, input int hold);
        int n;
        int lo;
        int hi;
        logic off;
        logic on_ok;
        logic [3:0] v;
        n = lvl ? int'(nr) : int'(nf);
        lo = fast ? (n * 5 + 7) / 8 - 1 : n;
        hi = fast ? (n * 5 + 7) / 8 + 1 : n;
        off = lvl ? b_on : a_on;
        on_ok = (hold >= hi + 8);
        if (off)
            ev_q.push_back('{lvl, ~(lvl ? pol_b : pol_a), cyc, 4, 7});
        if (on_ok)
            ev_q.push_back('{~lvl, lvl ? pol_a : pol_b, off ? -1 : cyc,
                             off ? lo : lo + 4, off ? hi : hi + 7});
        if (lvl) begin
            b_on = 1'b0;
            a_on = on_ok;
        end else begin
            a_on = 1'b0;
            b_on = on_ok;
        end
        repeat (hold) begin
            v = 4'($urandom);
            v[sel] = lvl;
            srcs <= v;
            @(posedge ref_clk);
        end
    endtask

    // watcher: read data and pin changes against the oldest notes
    always @(posedge ref_clk) begin
        logic [1:0] ch;
        cdg_note_t n;
        if (rd_seen) begin
            if (rd_q.size() == 0) err("read data without a note");
            else cmp8(reg_rdata, rd_q.pop_front());
        end
        rd_seen = reg_rd;
        ch = {pin_b !== prev_b, pin_a !== prev_a};
        if (!watch) ch = 2'b00;
        if (watch && pol_a && pol_b && both_on) err("both switches on");
        while (ch != 2'b00) begin
            if (ev_q.size() == 0 || !ch[ev_q[0].pin]) begin
                err("unexpected pin change");
                ch = 2'b00;
            end else begin
                n = ev_q.pop_front();
                ch[n.pin] = 1'b0;
                cmp_ev(n, n.pin ? pin_b : pin_a);
            end
        end
        prev_a = pin_a;
        prev_b = pin_b;
    end

    initial begin
        #(20000 * 100);
        num_errors++;
        $display("ERROR at %0t: watchdog expired", $time);
        results();
    end

    initial begin
        ref_clk = 1'b0;
        nrst = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        srcs = 4'h0;
        watch = 1'b0;
        cyc = 0;
        num_errors = 0;
        check_count = 0;
        exp_rb = '{CDG_CTRL0_MASK, CDG_CTRL1_MASK, 8'h3F, 8'h3F, 8'h00, 8'h00};
        nr_tab = '{6'h00, 6'h3F, 6'h03, 6'h10};
        nf_tab = '{6'h00, 6'h02, 6'h00, 6'h18};
        void'($urandom(63));
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        for (int i = 0; i < 6; i++)
            rd(3'(i), 8'h00);
        for (int i = 0; i < 6; i++)
            wr(3'(i), 8'hFF);
        for (int i = 0; i < 6; i++)
            if (i != 4) rd(3'(i), exp_rb[i]);
        wr(CDG_REG_CTRL0, 8'h00);
        wr(CDG_REG_CTRL1, 8'h00);
        done("registers");
        // enable with primary only, both polarities low
        wr(CDG_REG_CTRL0, 8'hA0);
        chk_pins(4'b1100);
        wr(CDG_REG_CTRL0, 8'h78);
        chk_pins(4'b0000);
        wr(CDG_REG_CTRL1, 8'hA0);
        wr(CDG_REG_CTRL0, 8'hE0);
        chk_pins(4'b1110);
        rd(CDG_REG_STATUS, 8'h08);
        wr(CDG_REG_CTRL1, 8'hC0);
        chk_pins(4'b1011);
        rd(CDG_REG_STATUS, 8'h10);
        wr(CDG_REG_CTRL0, 8'h00);
        wr(CDG_REG_CTRL1, 8'h00);
        done("enables");
        for (int s = 0; s < 4; s++) begin
            srcs <= 4'h0;
            sel = 2'(s);
            pol_a = s[0];
            pol_b = s[1];
            fast = (s == 3);
            nr = nr_tab[s];
            nf = (s == 2) ? 6'($urandom_range(0, 63)) : nf_tab[s];
            wr(CDG_REG_RISE_DB, {2'b00, nr});
            wr(CDG_REG_FALL_DB, {2'b00, nf});
            wr(CDG_REG_CTRL1, {6'h00, sel});
            wr(CDG_REG_CTRL0, {3'b111, pol_b, pol_a, 2'b00, fast});
            repeat (8) @(posedge ref_clk);
            a_on = 1'b0;
            b_on = 1'b0;
            watch <= 1'b1;
            @(posedge ref_clk);
            src_edge(1'b1, 80);
            src_edge(1'b0, 80);
            if (nr > 9) src_edge(1'b1, 3);
            if (nr > 9) src_edge(1'b0, 80);
            if (nr > 9) src_edge(1'b1, 1);
            if (nr > 9) src_edge(1'b0, 80);
            src_edge(1'b1, 80);
            src_edge(1'b0, 80);
            watch <= 1'b0;
            wr(CDG_REG_CTRL0, 8'h00);
            done($sformatf("waveform source %0d", s));
        end
        repeat (10) @(posedge ref_clk);
        if (rd_q.size() + ev_q.size() != 0) err("expected results never seen");
        results();
    end
endmodule
